// [design/adc_params.svh]
// Constants for the converter control and host output logic.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// Clock and timing
`define CLK_MHZ            50
`define CONV_TIME_NS       700
`define CAL_TIME_NS        2000
`define CONV_CYCLES        ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CAL_CYCLES         ((`CAL_TIME_NS * `CLK_MHZ + 999) / 1000)
`define SCLK_HALF_CYCLES   2

// Result word and pin map
`define RESULT_BITS        18
`define MODE_SERIAL        2'h3
`define PIN_SER_DATA       10
`define PIN_SER_CLK        11
`define PIN_FRAME_SYNC     12
`define PIN_READ_ERR       13
`define PIN_ALWAYS_OUT     14

// Reset values
`define PIN_OUT_RST        18'h00000
`define PIN_OE_N_RST       18'h3FFFF
`define FIFO_DEPTH_DEF     4

`endif

// [design/adc_types_pkg.sv]
// Types shared by the converter control and host output logic.
// Assumes the constants header is included by the users of these types.
package adc_types_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_LATCH = 2'b10,
    ST_CAL   = 2'b11
  } conv_state_e;

  // Host pins after synchronisation
  typedef struct packed {
    logic       convert_start_n;
    logic       reset_pin;
    logic       power_down_in;
    logic       cs_n;
    logic       rd_n;
    logic       sclk;
    logic       serial_clock_source_sel;
    logic       frame_sync_polarity_sel;
    logic [1:0] mode;
    logic       ref_power_down;
    logic       ref_buffer_power_down;
  } pin_in_s;

endpackage

// [design/result_fifo.sv]
// Small result FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clr_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count_q != CW'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (clr_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + AW'(1) : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
      count_q  <= count_q + CW'(push) - CW'(pop);
    end
  end

endmodule // result_fifo

// [design/adc_conversion_host_interface.sv]
// Conversion control and host output port of a sampling converter.
// Assumes host pins are asynchronous; sample_i comes from the core on clk_i.
`timescale 1ns/1ps
`include "adc_params.svh"

module adc_conversion_host_interface #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Conversion control pins
  input  wire logic        convert_start_n_i,
  input  wire logic        reset_pin_i,
  input  wire logic        power_down_in_i,
  // Host read port pins
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        sclk_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        serial_clock_source_sel_i,
  input  wire logic        frame_sync_polarity_sel_i,
  // Reference control pins
  input  wire logic        ref_power_down_i,
  input  wire logic        ref_buffer_power_down_i,
  // Core result
  input  wire logic [17:0] sample_i,
  // Status and core control
  output logic             busy_o,
  output logic             hold_o,
  output logic             low_power_o,
  output logic             ref_enable_o,
  output logic             ref_buffer_enable_o,
  // Data pins
  output logic [17:0]      data_o,
  output logic [17:0]      data_oe_n_o
);
  localparam int W = `RESULT_BITS;
  localparam logic [7:0] CONV_LOAD = 8'(`CONV_CYCLES - 1);
  localparam logic [7:0] CAL_LOAD  = 8'(`CAL_CYCLES - 1);
  localparam logic [3:0] HALF_LOAD = 4'(`SCLK_HALF_CYCLES - 1);
  localparam logic [4:0] LAST_BIT  = 5'(W - 1);

  // Reset release and pin synchronisers
  logic                   rst_meta_q;
  logic                   rst_n_q;
  adc_types_pkg::pin_in_s pin_raw;
  adc_types_pkg::pin_in_s pin_meta_q;
  adc_types_pkg::pin_in_s p;

  assign pin_raw = '{convert_start_n: convert_start_n_i,
                     reset_pin: reset_pin_i,
                     power_down_in: power_down_in_i,
                     cs_n: cs_n_i,
                     rd_n: rd_n_i,
                     sclk: sclk_i,
                     serial_clock_source_sel: serial_clock_source_sel_i,
                     frame_sync_polarity_sel: frame_sync_polarity_sel_i,
                     mode: mode_i,
                     ref_power_down: ref_power_down_i,
                     ref_buffer_power_down: ref_buffer_power_down_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_meta_q <= '{cs_n: 1'b1, rd_n: 1'b1, default: '0};
      p          <= '{cs_n: 1'b1, rd_n: 1'b1, default: '0};
    end else begin
      pin_meta_q <= pin_raw;
      p          <= pin_meta_q;
    end
  end

  // Edge history of synchronised pins
  logic cnv_prev_q;
  logic rstp_prev_q;
  logic sclk_prev_q;
  logic rd_en_prev_q;

  wire rd_en    = ~p.cs_n & ~p.rd_n;
  wire cnv_fall = cnv_prev_q & ~p.convert_start_n;
  wire rst_fall = rstp_prev_q & ~p.reset_pin;
  wire serial   = (p.mode == `MODE_SERIAL);
  wire master   = serial & ~p.serial_clock_source_sel;
  wire slave    = serial & p.serial_clock_source_sel;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnv_prev_q   <= 1'b0;
      rstp_prev_q  <= 1'b0;
      sclk_prev_q  <= 1'b0;
      rd_en_prev_q <= 1'b0;
    end else begin
      cnv_prev_q   <= p.convert_start_n;
      rstp_prev_q  <= p.reset_pin;
      sclk_prev_q  <= p.sclk;
      rd_en_prev_q <= rd_en;
    end
  end

  // Conversion sequencer
  adc_types_pkg::conv_state_e state_q;
  adc_types_pkg::conv_state_e state_d;
  logic [7:0]                 cnt_q;
  logic [7:0]                 cnt_d;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic [W-1:0]               fifo_out_data;

  wire idle     = (state_q == adc_types_pkg::ST_IDLE);
  wire cal_st   = (state_q == adc_types_pkg::ST_CAL);
  // Result waits in the latch state while the FIFO is full
  wire push     = (state_q == adc_types_pkg::ST_LATCH) & fifo_in_ready;
  wire cnt_zero = (cnt_q == 8'h00);
  wire start_ok = idle & cnv_fall & ~p.power_down_in;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_zero ? 8'h00 : cnt_q - 8'h01;
    case (state_q)
      adc_types_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_d = adc_types_pkg::ST_CONV;
          cnt_d   = CONV_LOAD;
        end
      end
      adc_types_pkg::ST_CONV: begin
        if (cnt_zero) begin
          state_d = adc_types_pkg::ST_LATCH;
        end
      end
      adc_types_pkg::ST_LATCH: begin
        if (fifo_in_ready) begin
          state_d = adc_types_pkg::ST_IDLE;
        end
      end
      adc_types_pkg::ST_CAL: begin
        if (cnt_zero) begin
          state_d = adc_types_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = adc_types_pkg::ST_IDLE;
      end
    endcase
    if (p.reset_pin) begin
      state_d = adc_types_pkg::ST_IDLE;
      cnt_d   = 8'h00;
    end else if (rst_fall) begin
      state_d = adc_types_pkg::ST_CAL;
      cnt_d   = CAL_LOAD;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= adc_types_pkg::ST_IDLE;
      cnt_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Word store and serial shifter
  logic [W-1:0] shreg_q;
  logic         word_valid_q;
  logic [4:0]   bit_cnt_q;
  logic         shift_q;
  logic [3:0]   half_q;
  logic         sclk_gen_q;

  wire pop         = ~word_valid_q & fifo_out_valid & ~p.reset_pin;
  wire master_tick = shift_q & (half_q == 4'h0);
  wire master_fall = master_tick & sclk_gen_q;
  // External clock edges count only while chip select is low
  wire slave_edge  = slave & word_valid_q & ~p.cs_n
                   & p.sclk & ~sclk_prev_q;
  wire shift_edge  = master_fall | slave_edge;
  wire last_bit    = shift_edge & (bit_cnt_q == LAST_BIT);
  wire rderr_hit   = slave & push & (bit_cnt_q != 5'h00);
  wire par_done    = ~serial & rd_en_prev_q & ~rd_en;
  wire consumed    = last_bit | par_done | rderr_hit | p.reset_pin;
  wire start_m     = master & rd_en & word_valid_q & ~shift_q;

  wire [W-1:0] shreg_d = pop ? fifo_out_data
                       : shift_edge ? {shreg_q[W-2:0], 1'b0} : shreg_q;
  wire         word_valid_d = pop | (word_valid_q & ~consumed);
  wire [4:0]   bit_cnt_d = (last_bit | rderr_hit | pop | p.reset_pin)
                         ? 5'h00
                         : shift_edge ? bit_cnt_q + 5'h01 : bit_cnt_q;
  wire         shift_d = start_m
                       | (shift_q & master & ~last_bit & ~p.reset_pin);
  wire [3:0]   half_d = (~shift_q | master_tick) ? HALF_LOAD
                      : half_q - 4'h1;
  wire         sclk_gen_d = shift_d & (sclk_gen_q ^ master_tick);

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shreg_q      <= '0;
      word_valid_q <= 1'b0;
      bit_cnt_q    <= 5'h00;
      shift_q      <= 1'b0;
      half_q       <= 4'h0;
      sclk_gen_q   <= 1'b0;
    end else begin
      shreg_q      <= shreg_d;
      word_valid_q <= word_valid_d;
      bit_cnt_q    <= bit_cnt_d;
      shift_q      <= shift_d;
      half_q       <= half_d;
      sclk_gen_q   <= sclk_gen_d;
    end
  end

  result_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_q),
    .clr_i       (p.reset_pin),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sample_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  // Pin drive selection
  wire         sync_level = shift_q ^ p.frame_sync_polarity_sel;
  wire [17:0]  ser_pins   = {4'h0, rderr_hit, sync_level, sclk_gen_q,
                             shreg_q[W-1], 10'h000};
  wire [17:0]  ser_oe_n   = {4'h0, 1'b0, 1'b0, ~master, ~rd_en,
                             10'h3FF};
  wire [17:0]  par_oe_n   = {4'h0, {14{~rd_en}}};
  wire [17:0]  pins_d     = serial ? ser_pins : shreg_q;
  wire [17:0]  oe_n_d     = serial ? ser_oe_n : par_oe_n;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_o              <= `PIN_OUT_RST;
      data_oe_n_o         <= `PIN_OE_N_RST;
      busy_o              <= 1'b0;
      hold_o              <= 1'b0;
      low_power_o         <= 1'b0;
      ref_enable_o        <= 1'b0;
      ref_buffer_enable_o <= 1'b0;
    end else begin
      data_o              <= pins_d;
      data_oe_n_o         <= oe_n_d;
      busy_o              <= (state_d != adc_types_pkg::ST_IDLE);
      hold_o              <= (state_d == adc_types_pkg::ST_CONV);
      low_power_o         <= p.power_down_in & idle;
      ref_enable_o        <= ~p.ref_power_down;
      ref_buffer_enable_o <= ~p.ref_buffer_power_down;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  wire stop_ok = push | cal_st | p.reset_pin;

  busy_rise_a: assert property (
    start_ok && !p.reset_pin |=> busy_o && hold_o [*8])
    else $error("busy or hold not raised by conversion start");
  busy_fall_a: assert property (
    $fell(busy_o) |-> $past(stop_ok))
    else $error("busy fell without latch, calibration end or reset");
  hold_start_a: assert property (
    start_ok && !p.reset_pin |=> state_q == adc_types_pkg::ST_CONV)
    else $error("falling convert start did not begin conversion");
  reset_abort_a: assert property (
    p.reset_pin |=> idle && !hold_o)
    else $error("reset pin did not abort conversion");
  cal_pulse_a: assert property (
    rst_fall |=> cal_st && busy_o)
    else $error("calibration not entered after reset pin fall");
  power_down_a: assert property (
    idle && p.power_down_in && !rst_fall |=> idle)
    else $error("conversion started while powered down");
  top_pins_a: assert property (
    rst_n_q |=> data_oe_n_o[17:14] == 4'h0)
    else $error("pins 14 to 17 not driven");
  bus_enable_a: assert property (
    !rd_en |=> data_oe_n_o[10] && (serial || data_oe_n_o[0]))
    else $error("output bus enabled without chip select and read");
  sync_high_a: assert property (
    master && !p.frame_sync_polarity_sel && shift_q |=> data_o[12])
    else $error("frame sync not high during master frame");
  sync_low_a: assert property (
    master && p.frame_sync_polarity_sel && shift_q |=> !data_o[12])
    else $error("frame sync not low during master frame");
  read_err_a: assert property (
    rderr_hit |=> data_o[13] && !word_valid_q ##1 !data_o[13])
    else $error("incomplete read not flagged as one pulse");
  clk_gate_a: assert property (
    slave && p.cs_n && word_valid_q |=> shreg_q == $past(shreg_q))
    else $error("serial clock shifted while chip select high");
  par_pins_a: assert property (
    !serial |=> data_o == $past(shreg_q))
    else $error("parallel pins do not show the result word");

  conv_done_c: cover property (push ##1 !busy_o);
  master_frame_c: cover property (start_m ##[1:200] last_bit);
  read_err_c: cover property (rderr_hit);
  cal_done_c: cover property (cal_st ##1 idle);

endmodule // adc_conversion_host_interface

// [verification/host_serial_reader.sv]
// Host model that clocks results out of the slave serial port.
// Assumes the device shows its result MSB first on the data pin.
`timescale 1ns/1ps
module host_serial_reader (
  // Serial link
  output logic      sclk_o,
  input  wire logic data_i
);
  // Clock stands low between frames
  initial sclk_o = 1'b0;

  // 160 ns period, data taken just before each rising edge
  task automatic read_bits(input int n, output logic [17:0] w);
    w = 18'h00000;
    for (int i = 0; i < n; i++) begin
      #80;
      w = {w[16:0], data_i};
      sclk_o <= 1'b1;
      #80;
      sclk_o <= 1'b0;
    end
  endtask
endmodule // host_serial_reader

// [verification/tb_adc_conversion_host_interface.sv]
// Self-checking bench for the converter control and host output logic.
// Assumes the design header, package and FIFO are compiled first.
`timescale 1ns/1ps
`include "adc_params.svh"
module tb_adc_conversion_host_interface;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        convert_start_n_i = 1'b1;
  logic        reset_pin_i = 1'b0;
  logic        power_down_in_i = 1'b0;
  logic        cs_n_i = 1'b1;
  logic        rd_n_i = 1'b1;
  logic        sclk;
  logic [1:0]  mode_i = 2'h0;
  logic        serial_clock_source_sel_i = 1'b0;
  logic        frame_sync_polarity_sel_i = 1'b0;
  logic        ref_power_down_i = 1'b0;
  logic        ref_buffer_power_down_i = 1'b0;
  logic [17:0] sample_i = 18'h00000;
  logic        busy_o;
  logic        hold_o;
  logic        low_power_o;
  logic        ref_enable_o;
  logic        ref_buffer_enable_o;
  logic [17:0] data_o;
  logic [17:0] data_oe_n_o;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          flag_cnt = 0;
  int          seed = 32'hAC06;
  int          n;
  logic [17:0] got;
  logic [17:0] model_q[$];

  always #10 clk_i = ~clk_i;

  adc_conversion_host_interface #(.FIFO_DEPTH(4))
    adc_conversion_host_interface_i (
    .clk_i, .rst_n_i, .convert_start_n_i, .reset_pin_i, .power_down_in_i,
    .cs_n_i, .rd_n_i, .sclk_i(sclk), .mode_i, .serial_clock_source_sel_i,
    .frame_sync_polarity_sel_i, .ref_power_down_i, .ref_buffer_power_down_i,
    .sample_i, .busy_o, .hold_o, .low_power_o, .ref_enable_o,
    .ref_buffer_enable_o, .data_o, .data_oe_n_o);

  // Released data pin reads as the inverse of its last level
  host_serial_reader host_serial_reader_i (.sclk_o(sclk),
    .data_i(data_o[10] ^ data_oe_n_o[10]));

  // Pin 13 is the read error flag only in serial mode
  always @(posedge clk_i) begin
    if (mode_i == 2'h3 && data_o[13] === 1'b1) begin
      flag_cnt <= flag_cnt + 1;
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic chk_vec(input string what, input logic [17:0] e,
                         input logic [17:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_num(input string what, input int e, input int g);
    n_tests++;
    if (g != e) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic wait_busy(input logic v, input int lim, output int k);
    k = 0;
    while (busy_o !== v && k < lim) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic convert(input bit done, output int w);
    logic [17:0] v;
    v = 18'($random(seed));
    sample_i <= v;
    convert_start_n_i <= 1'b0;
    wait_busy(1'b1, 20, w);
    chk_vec("hold at start", 18'h00001, {17'h0, hold_o});
    convert_start_n_i <= 1'b1;
    model_q.push_back(v);
    if (done) begin
      wait_busy(1'b0, 200, w);
      chk_vec("hold at busy fall", 18'h00000, {17'h0, hold_o});
      chk_num("busy width", 1,
              int'(w >= `CONV_CYCLES && w <= `CONV_CYCLES + 4));
    end
  endtask

  task automatic read_par(input logic [1:0] m);
    mode_i <= m;
    cs_n_i <= 1'b0;
    rd_n_i <= 1'b0;
    cyc(4);
    chk_vec("oe parallel", 18'h00000, data_oe_n_o);
    chk_vec("parallel word", model_q.pop_front(), data_o);
    rd_n_i <= 1'b1;
    cyc(4);
    chk_vec("oe released", 18'h03FFF, data_oe_n_o);
    cs_n_i <= 1'b1;
    cyc(2);
  endtask

  task automatic read_master(input logic p);
    int act;
    logic ck;
    got = 18'h00000;
    act = 0;
    ck = 1'b0;
    frame_sync_polarity_sel_i <= p;
    mode_i <= 2'h3;
    cyc(4);
    convert(1'b1, n);
    chk_vec("sync idle", {17'h0, p}, {17'h0, data_o[12]});
    cs_n_i <= 1'b0;
    rd_n_i <= 1'b0;
    for (int i = 0; i < 300 && !(act > 0 && data_o[12] === p); i++) begin
      @(posedge clk_i);
      if (data_o[12] === ~p) begin
        act++;
        if (act == 10) begin
          chk_vec("oe master", 18'h003FF, data_oe_n_o);
        end
        if (!ck && data_o[11] === 1'b1) begin
          got = {got[16:0], data_o[10]};
        end
      end
      ck = data_o[11];
    end
    cs_n_i <= 1'b1;
    rd_n_i <= 1'b1;
    chk_num("sync active cycles",
            2 * `SCLK_HALF_CYCLES * `RESULT_BITS, act);
    chk_vec("master word", model_q.pop_front(), got);
    cyc(6);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // About fifteen times the expected run length
  initial begin
    #400000;
    n_mismatch++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    cyc(16);
    rst_n_i <= 1'b1;
    cyc(6);
    chk_vec("oe after reset", 18'h03FFF, data_oe_n_o);
    for (int i = 0; i < 3; i++) begin
      ref_power_down_i <= (i > 0);
      ref_buffer_power_down_i <= (i == 2);
      cyc(5);
      chk_vec("reference enables", {16'h0, i == 0, i != 2},
              {16'h0, ref_enable_o, ref_buffer_enable_o});
    end
    $display("test reference done");

    convert(1'b0, n);
    power_down_in_i <= 1'b1;
    wait_busy(1'b0, 200, n);
    chk_vec("finish under power down", 18'h00000, {17'h0, busy_o});
    cyc(4);
    chk_vec("low power", 18'h00001, {17'h0, low_power_o});
    convert_start_n_i <= 1'b0;
    wait_busy(1'b1, 40, n);
    chk_num("start refused", 40, n);
    convert_start_n_i <= 1'b1;
    power_down_in_i <= 1'b0;
    cyc(4);
    repeat (4) convert(1'b1, n);
    convert(1'b0, n);
    wait_busy(1'b0, `CONV_CYCLES + 30, n);
    chk_vec("busy while full", 18'h00001, {17'h0, busy_o});
    for (int i = 0; i < 6; i++) begin
      read_par(2'(i % 3));
    end
    chk_vec("busy after drain", 18'h00000, {17'h0, busy_o});
    $display("test parallel done");

    convert(1'b0, n);
    cyc(10);
    reset_pin_i <= 1'b1;
    cyc(8);
    chk_vec("abort", 18'h00000, {16'h0, busy_o, hold_o});
    model_q.delete();
    reset_pin_i <= 1'b0;
    wait_busy(1'b1, 10, n);
    chk_vec("calibration busy", 18'h00001, {17'h0, busy_o});
    wait_busy(1'b0, 200, n);
    chk_num("calibration width", 1,
            int'(n >= `CAL_CYCLES && n <= `CAL_CYCLES + 4));
    $display("test reset done");

    read_master(1'b0);
    read_master(1'b1);
    $display("test master serial done");

    serial_clock_source_sel_i <= 1'b1;
    cyc(4);
    convert(1'b1, n);
    convert(1'b1, n);
    host_serial_reader_i.read_bits(3, got);
    @(posedge clk_i);
    cs_n_i <= 1'b0;
    rd_n_i <= 1'b0;
    cyc(4);
    chk_vec("oe slave", 18'h00BFF, data_oe_n_o);
    host_serial_reader_i.read_bits(18, got);
    chk_vec("slave word", model_q.pop_front(), got);
    cyc(8);
    host_serial_reader_i.read_bits(5, got);
    @(posedge clk_i);
    flag_cnt = 0;
    convert(1'b1, n);
    cyc(4);
    chk_num("read error pulses", 1, flag_cnt);
    void'(model_q.pop_front());
    host_serial_reader_i.read_bits(18, got);
    chk_vec("slave after discard", model_q.pop_front(), got);
    $display("test slave serial done");
    stop_test();
  end
endmodule // tb_adc_conversion_host_interface
